// File: logic/link_ctrl_regs.sv
// link control register bank with transmit, receive, busy and grant hold logic
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`include "llc_cfg.svh"

// Overview of operation
// - each byte goes out highest bit first
// - each word goes out highest byte first
// - bit 00:07 sits in top byte lane
// - readable, writable and hardware-updated fields honoured
// - fixed identification word at 00, writes ignored
// - word at 04 reserved, no function
// - control bit 0 issues a device reset
// - bit 3 picks lower or upper RAM half
// - bit 4 forces busy on every packet
// - transmitter idle while bit 5 clear
// - receiver idle while bit 6 clear
// - bit 10 resets transmitter, then self-clears
// - bit 11 resets receiver, then self-clears
// - bit 14 stretches grant hold to ten
// - bit 23 clears self-ID error, self-clears
// - bit 27 drives the power switch pin
// - control bits power up zero except bits 5 and 6, which power up one
// - interrupt bit 7 flags self-ID error; there is no interrupt word here, the flag only drives sid_error_flag
module link_ctrl_regs #(
    parameter int WORD_W = 32  // serial word width
) (
    input  wire logic                   mclk,
    input  wire logic                   nrst,
    input  wire llc_pkg::reg_req_t      bus_req,
    output logic [31:0]                 bus_rdata,
    input  wire logic [7:0]             cpu_data_addr,
    output logic [8:0]                  ram_addr,
    input  wire logic [WORD_W-1:0]      tx_word,
    input  wire logic                   tx_valid,
    output logic                        tx_ready,
    output logic                        tx_arb_req,
    output logic                        tx_bit,
    output logic                        tx_bit_valid,
    input  wire logic                   rx_bit,
    input  wire logic                   rx_bit_valid,
    input  wire logic                   rx_congested,
    output logic [WORD_W-1:0]           rx_word,
    output logic                        rx_word_valid,
    output logic                        busy_ack,
    input  wire logic                   bus_grant,
    output logic                        grant_hold,
    input  wire logic                   sid_error_event,
    output logic                        sid_error_flag,
    output logic                        device_reset,
    output logic                        tx_reset,
    output logic                        rx_reset,
    output logic                        power_switch_output
);

    // position 00 is the top bit of the word, so flip the index
    function automatic logic [4:0] lane(input int pos);
        lane = 5'(31 - pos);
    endfunction

    // byte address decode against one offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // stored control fields
    llc_pkg::ctl_t ctl_q;             // writable fields
    logic          sw_reset_q;        // self-clearing device reset
    logic          tx_srst_q;         // self-clearing transmit reset
    logic          rx_srst_q;         // self-clearing receive reset
    logic          sid_clr_q;         // self-clearing error clear
    logic          sid_err_q;         // self-ID error flag
    logic [31:0]   rdata_q;           // read data register
    logic          ctl_wr;            // write to control word
    logic [31:0]   ctl_word;          // control word as read

    assign ctl_wr = bus_req.wr && hit(bus_req.addr, `OFS_LINK_CTRL);

    // writable control fields; everything not listed is dropped
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctl_q.bank_sel  <= `RST_ZERO;
            ctl_q.busy_all  <= `RST_ZERO;
            ctl_q.tx_en     <= `RST_TX_EN;
            ctl_q.rx_en     <= `RST_RX_EN;
            ctl_q.long_hold <= `RST_ZERO;
            ctl_q.pwr_sw    <= `RST_ZERO;
        end else if (ctl_wr) begin
            // reserved positions are simply never stored
            ctl_q.bank_sel  <= bus_req.wdata[lane(`POS_BANK_SEL)];
            ctl_q.busy_all  <= bus_req.wdata[lane(`POS_BUSY_POL)];
            ctl_q.tx_en     <= bus_req.wdata[lane(`POS_TX_EN)];
            ctl_q.rx_en     <= bus_req.wdata[lane(`POS_RX_EN)];
            ctl_q.long_hold <= bus_req.wdata[lane(`POS_LONG_HOLD)];
            ctl_q.pwr_sw    <= bus_req.wdata[lane(`POS_PWR_SW)];
        end
    end

    // self-clearing strobes: set by a write of one, gone next cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sw_reset_q <= `RST_ZERO;
            tx_srst_q  <= `RST_ZERO;
            rx_srst_q  <= `RST_ZERO;
            sid_clr_q  <= `RST_ZERO;
        end else begin
            sw_reset_q <= ctl_wr && bus_req.wdata[lane(`POS_SW_RESET)];
            tx_srst_q  <= ctl_wr && bus_req.wdata[lane(`POS_TX_SRST)];
            rx_srst_q  <= ctl_wr && bus_req.wdata[lane(`POS_RX_SRST)];
            sid_clr_q  <= ctl_wr && bus_req.wdata[lane(`POS_SID_CLR)];
        end
    end

    // self-ID error flag; a new error beats a clear in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sid_err_q <= `RST_ZERO;
        end else if (sid_error_event) begin
            sid_err_q <= 1'b1;
        end else if (sid_clr_q) begin
            sid_err_q <= 1'b0;
        end
    end

    // control word image; reserved bits stay zero
    always_comb begin
        ctl_word = 32'h0000_0000;
        ctl_word[lane(`POS_SW_RESET)]  = sw_reset_q;
        ctl_word[lane(`POS_BANK_SEL)]  = ctl_q.bank_sel;
        ctl_word[lane(`POS_BUSY_POL)]  = ctl_q.busy_all;
        ctl_word[lane(`POS_TX_EN)]     = ctl_q.tx_en;
        ctl_word[lane(`POS_RX_EN)]     = ctl_q.rx_en;
        ctl_word[lane(`POS_TX_SRST)]   = tx_srst_q;
        ctl_word[lane(`POS_RX_SRST)]   = rx_srst_q;
        ctl_word[lane(`POS_LONG_HOLD)] = ctl_q.long_hold;
        ctl_word[lane(`POS_PWR_SW)]    = ctl_q.pwr_sw;
        // the clear strobe is write-only and reads zero
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (!bus_req.rd) begin
            rdata_q <= 32'h0000_0000;
        end else if (hit(bus_req.addr, `OFS_PART_ID)) begin
            rdata_q <= `PART_ID_VALUE;
        end else if (hit(bus_req.addr, `OFS_LINK_CTRL)) begin
            rdata_q <= ctl_word;
        end else begin
            // reserved word and unmapped addresses read zero
            rdata_q <= 32'h0000_0000;
        end
    end

    assign bus_rdata           = rdata_q;
    assign device_reset        = sw_reset_q;
    assign tx_reset            = tx_srst_q;
    assign rx_reset            = rx_srst_q;
    assign sid_error_flag      = sid_err_q;
    assign power_switch_output = ctl_q.pwr_sw;

    // processor sees 256 bytes; the bank bit picks the RAM half
    assign ram_addr = {ctl_q.bank_sel, cpu_data_addr[`PAGE_ADDR_BITS-1:0]};

    // ---------------- transmitter ----------------
    llc_pkg::tx_state_t  tx_state_q;  // serializer state
    logic [WORD_W-1:0]   tx_shift_q;  // word being shifted out
    logic [5:0]          tx_cnt_q;    // bits left to send

    // a word is only taken while enabled and not in soft reset
    assign tx_ready   = (tx_state_q == llc_pkg::TX_IDLE) && ctl_q.tx_en && !tx_srst_q;
    assign tx_arb_req = (tx_state_q == llc_pkg::TX_SEND);

    // shift top bit first: top byte first, top bit of each byte first
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_state_q <= llc_pkg::TX_IDLE;
            tx_shift_q <= '0;
            tx_cnt_q   <= 6'h00;
        end else if (tx_srst_q || !ctl_q.tx_en) begin
            // soft reset or disable abandons the word in flight
            tx_state_q <= llc_pkg::TX_IDLE;
            tx_cnt_q   <= 6'h00;
        end else begin
            case (tx_state_q)
                llc_pkg::TX_IDLE: begin
                    if (tx_valid) begin
                        tx_shift_q <= tx_word;
                        tx_cnt_q   <= `WORD_BITS;
                        tx_state_q <= llc_pkg::TX_SEND;
                    end
                end
                llc_pkg::TX_SEND: begin
                    tx_shift_q <= {tx_shift_q[WORD_W-2:0], 1'b0};
                    tx_cnt_q   <= tx_cnt_q - 6'h01;
                    if (tx_cnt_q == 6'h01) begin
                        tx_state_q <= llc_pkg::TX_IDLE;
                    end
                end
                default: begin
                    tx_state_q <= llc_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // serial output registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_bit       <= 1'b0;
            tx_bit_valid <= 1'b0;
        end else begin
            tx_bit       <= tx_shift_q[WORD_W-1];
            tx_bit_valid <= (tx_state_q == llc_pkg::TX_SEND) && ctl_q.tx_en && !tx_srst_q;
        end
    end

    // ---------------- receiver ----------------
    logic [WORD_W-1:0] rx_shift_q;   // assembling word
    logic [5:0]        rx_cnt_q;     // bits gathered so far
    logic              rx_take;      // bit accepted this cycle

    // disabled receiver drops incoming bits
    assign rx_take = rx_bit_valid && ctl_q.rx_en && !rx_srst_q;

    // first bit lands at the top of the word
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_shift_q    <= '0;
            rx_cnt_q      <= 6'h00;
            rx_word       <= '0;
            rx_word_valid <= 1'b0;
        end else if (rx_srst_q) begin
            rx_cnt_q      <= 6'h00;
            rx_word_valid <= 1'b0;
        end else begin
            rx_word_valid <= 1'b0;
            if (rx_take) begin
                rx_shift_q <= {rx_shift_q[WORD_W-2:0], rx_bit};
                if (rx_cnt_q == `WORD_BITS - 6'h01) begin
                    rx_word       <= {rx_shift_q[WORD_W-2:0], rx_bit};
                    rx_word_valid <= 1'b1;
                    rx_cnt_q      <= 6'h00;
                end else begin
                    rx_cnt_q <= rx_cnt_q + 6'h01;
                end
            end
        end
    end

    // busy answer per finished word: forced or only when congested
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_ack <= 1'b0;
        end else begin
            busy_ack <= rx_take && (rx_cnt_q == `WORD_BITS - 6'h01)
                        && (ctl_q.busy_all || rx_congested);
        end
    end

    // ---------------- grant hold ----------------
    logic [3:0] hold_cnt_q;  // hold cycles left

    // a grant restarts the hold; long mode gives ten cycles
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hold_cnt_q <= 4'h0;
        end else if (bus_grant) begin
            hold_cnt_q <= ctl_q.long_hold ? `HOLD_LONG_CYC : `HOLD_SHORT_CYC;
        end else if (hold_cnt_q != 4'h0) begin
            hold_cnt_q <= hold_cnt_q - 4'h1;
        end
    end

    assign grant_hold = (hold_cnt_q != 4'h0);

    // ---------------- checks ----------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_id_read;
        bus_req.rd && bus_req.addr == `OFS_PART_ID |=> bus_rdata == `PART_ID_VALUE;
    endproperty
    a_id_read: assert property (p_id_read) else $error("id word wrong");

    property p_rsvd_read;
        bus_req.rd && bus_req.addr == `OFS_RSVD_FOUR |=> bus_rdata == 32'h0000_0000;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved word not zero");

    property p_txsrst_pulse;
        ctl_wr && bus_req.wdata[lane(`POS_TX_SRST)] |=> tx_reset ##1 (!tx_reset || $past(ctl_wr));
    endproperty
    a_txsrst_pulse: assert property (p_txsrst_pulse) else $error("tx reset stuck");

    property p_rxsrst_pulse;
        ctl_wr && bus_req.wdata[lane(`POS_RX_SRST)] |=> rx_reset ##1 (!rx_reset || $past(ctl_wr));
    endproperty
    a_rxsrst_pulse: assert property (p_rxsrst_pulse) else $error("rx reset stuck");

    property p_tx_gated;
        !ctl_q.tx_en |=> !tx_arb_req;
    endproperty
    a_tx_gated: assert property (p_tx_gated) else $error("tx active while off");

    property p_rx_gated;
        !ctl_q.rx_en |=> !rx_word_valid;
    endproperty
    a_rx_gated: assert property (p_rx_gated) else $error("rx word while off");

    property p_long_hold;
        // grant at c0, no new grant through c10: high at c10, low at c11
        bus_grant && ctl_q.long_hold ##1 !bus_grant [*8] ##1 !bus_grant ##1 !bus_grant
            |-> grant_hold ##1 !grant_hold;
    endproperty
    a_long_hold: assert property (p_long_hold) else $error("long hold length wrong");

    property p_sid_clear;
        sid_clr_q && !sid_error_event |=> !sid_error_flag;
    endproperty
    a_sid_clear: assert property (p_sid_clear) else $error("error not cleared");

    property p_sid_set_wins;
        sid_error_event |=> sid_error_flag;
    endproperty
    a_sid_set_wins: assert property (p_sid_set_wins) else $error("error event lost");

    property p_pwr_pin;
        ctl_wr |=> power_switch_output == $past(bus_req.wdata[lane(`POS_PWR_SW)]);
    endproperty
    a_pwr_pin: assert property (p_pwr_pin) else $error("power pin mismatch");

    property p_msb_first;
        tx_ready && tx_valid |=> ##1 tx_bit == $past(tx_word[WORD_W-1], 2) || !tx_bit_valid;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit not top bit");

    property p_bank_addr;
        ram_addr[8] == ctl_q.bank_sel && ram_addr[7:0] == cpu_data_addr;
    endproperty
    a_bank_addr: assert property (p_bank_addr) else $error("bank address wrong");

    // short mode holds one cycle unless a fresh grant restarts it
    property p_short_hold;
        bus_grant && !ctl_q.long_hold |=> grant_hold ##1 (!grant_hold || $past(bus_grant));
    endproperty
    a_short_hold: assert property (p_short_hold) else $error("short hold length wrong");

    property p_busy_forced;
        rx_take && rx_cnt_q == `WORD_BITS - 6'h01 && ctl_q.busy_all
            |=> busy_ack && rx_word_valid;
    endproperty
    a_busy_forced: assert property (p_busy_forced) else $error("busy not forced");

    property p_rx_last_bit;
        rx_word_valid |-> rx_word[0] == $past(rx_bit);
    endproperty
    a_rx_last_bit: assert property (p_rx_last_bit) else $error("last bit misplaced");

    property p_tx_abort;
        tx_reset |=> !tx_arb_req;
    endproperty
    a_tx_abort: assert property (p_tx_abort) else $error("tx busy after reset");

    property p_rdata_idle;
        !bus_req.rd |=> bus_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

    property p_sid_clr_once;
        sid_clr_q |=> !sid_clr_q || $past(ctl_wr);
    endproperty
    a_sid_clr_once: assert property (p_sid_clr_once) else $error("clear strobe stuck");

    c_tx_word: cover property (tx_ready && tx_valid ##[1:40] !tx_arb_req);
    c_rx_word: cover property (rx_word_valid);
    c_busy_all: cover property (busy_ack && ctl_q.busy_all);
    c_sid_race: cover property (sid_error_event && sid_clr_q);

endmodule // link_ctrl_regs

// File: logic/llc_cfg.svh
// address map, field positions, reset values and timing counts of the control bank
`ifndef LLC_CFG_SVH
`define LLC_CFG_SVH

// word offsets (byte addresses)
`define OFS_PART_ID      8'h00
`define OFS_RSVD_FOUR    8'h04
`define OFS_LINK_CTRL    8'h08

// arbitrary identification value, not tied to any real part
`define PART_ID_VALUE    32'h0A5C_0001

// field positions, counted from the first (most significant) bit as 00
`define POS_SW_RESET     0
`define POS_BANK_SEL     3
`define POS_BUSY_POL     4
`define POS_TX_EN        5
`define POS_RX_EN        6
`define POS_TX_SRST      10
`define POS_RX_SRST      11
`define POS_LONG_HOLD    14
`define POS_SID_CLR      23
`define POS_PWR_SW       27

// power-on values of the stored control fields
`define RST_TX_EN        1'b1
`define RST_RX_EN        1'b1
`define RST_ZERO         1'b0

// grant hold lengths in clock cycles
`define HOLD_SHORT_CYC   4'h1
`define HOLD_LONG_CYC    4'hA

// serial word length and bank page size
`define WORD_BITS        6'h20
`define PAGE_ADDR_BITS   8

`endif

// File: logic/llc_pkg.sv
// shared carrier types for the link control bank
package llc_pkg;

    // one register bus request, all fields sampled together
    typedef struct packed {
        logic [7:0]  addr;   // byte address
        logic [31:0] wdata;  // write data
        logic        wr;     // write strobe
        logic        rd;     // read strobe
    } reg_req_t;

    // decoded control fields as the block logic uses them
    typedef struct packed {
        logic bank_sel;
        logic busy_all;
        logic tx_en;
        logic rx_en;
        logic long_hold;
        logic pwr_sw;
    } ctl_t;

    // transmit serializer states
    typedef enum logic [0:0] {
        TX_IDLE,
        TX_SEND
    } tx_state_t;

endpackage

// File: test/test_link_layer_control_registers.sv
// self-checking bench for the link control register bank
`timescale 1ns/10ps
`include "llc_cfg.svh"

module test_link_layer_control_registers;
    logic              mclk;           // 25 MHz bench clock
    logic              nrst;           // async reset, active low
    llc_pkg::reg_req_t req;            // register bus request
    logic [31:0]       bus_rdata;      // read data
    logic [7:0]        cpu_data_addr;  // processor data address
    logic [8:0]        ram_addr;       // banked ram address
    logic [31:0]       tx_word;        // word to send
    logic              tx_valid;       // send request
    logic              tx_ready;       // transmitter idle and enabled
    logic              tx_arb_req;     // arbitration request
    logic              tx_bit;         // serial out bit
    logic              tx_bit_valid;   // serial out qualifier
    logic              rx_bit;         // serial in bit
    logic              rx_bit_valid;   // serial in qualifier
    logic              rx_congested;   // receive side full
    logic [31:0]       rx_word;        // received word
    logic              rx_word_valid;  // received word pulse
    logic              busy_ack;       // busy acknowledge pulse
    logic              bus_grant;      // grant pulse
    logic              grant_hold;     // grant hold level
    logic              sid_error_event; // self-ID error pulse
    logic              sid_error_flag; // self-ID error flag
    logic              device_reset;   // device reset pulse
    logic              tx_reset;       // transmitter reset pulse
    logic              rx_reset;       // receiver reset pulse
    logic              power_switch_output; // power switch pin
    int                err_count;      // mismatches
    int                comparisons;    // compares made
    logic [31:0]       rd_val;         // last read value
    int                n;              // scratch counter

    // one row per register access: address, written value, expectations
    typedef struct {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
        logic        bank;
        logic        pwr;
        logic        txr;
    } row_t;
    row_t rows [7] = '{
        '{8'h08, 32'h7FCF_FEFF, 32'h1E02_0010, 1'b1, 1'b1, 1'b1},
        '{8'h08, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b0, 1'b0},
        '{8'h08, 32'h1000_0000, 32'h1000_0000, 1'b1, 1'b0, 1'b0},
        '{8'h00, 32'hFFFF_FFFF, `PART_ID_VALUE, 1'b1, 1'b0, 1'b0},
        '{8'h04, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 1'b0, 1'b0},
        '{8'h0C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 1'b0, 1'b0},
        '{8'h08, 32'h0600_0000, 32'h0600_0000, 1'b0, 1'b0, 1'b1}
    };
    logic [31:0] pulse_bits [3] = '{32'h8000_0000, 32'h0020_0000, 32'h0010_0000};
    logic [31:0] rx_ctl [4] = '{32'h0400_0000, 32'h0600_0000, 32'h0E00_0000, 32'h0600_0000};

    link_ctrl_regs #(.WORD_W(32)) DUT (
        .mclk(mclk), .nrst(nrst), .bus_req(req), .bus_rdata(bus_rdata),
        .cpu_data_addr(cpu_data_addr), .ram_addr(ram_addr), .tx_word(tx_word),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_arb_req(tx_arb_req),
        .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .rx_congested(rx_congested), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid), .busy_ack(busy_ack), .bus_grant(bus_grant),
        .grant_hold(grant_hold), .sid_error_event(sid_error_event),
        .sid_error_flag(sid_error_flag), .device_reset(device_reset),
        .tx_reset(tx_reset), .rx_reset(rx_reset),
        .power_switch_output(power_switch_output)
    );

    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // compare and count; four-state so unknowns never match
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // single verdict point
    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    // main sequence
    initial begin
        err_count = 0;
        comparisons = 0;
        nrst = 1'b0;
        req = '0;
        cpu_data_addr = 8'h5A;
        tx_word = 32'h0000_0000;
        tx_valid = 1'b0;
        rx_bit = 1'b0;
        rx_bit_valid = 1'b0;
        rx_congested = 1'b0;
        bus_grant = 1'b0;
        sid_error_event = 1'b0;
        repeat (5) @(posedge mclk);
        check("tx_ready_rst", tx_ready, 1);
        check("pwr_rst", power_switch_output, 0);
        nrst <= 1'b1;
        rd_reg(8'h08, rd_val);
        check("ctrl_rst", rd_val, 32'h0600_0000);
        // ordinary accesses from the table
        foreach (rows[i]) begin
            wr_reg(rows[i].addr, rows[i].wdata);
            rd_reg(rows[i].addr, rd_val);
            check("rd", rd_val, rows[i].rexp);
            check("ram_addr", ram_addr, {23'h0, rows[i].bank, 8'h5A});
            check("pwr", power_switch_output, rows[i].pwr);
            check("tx_ready", tx_ready, rows[i].txr);
        end
        // self-clearing strobes: device, transmitter, receiver
        foreach (pulse_bits[i]) begin
            wr_reg(8'h08, 32'h0600_0000 | pulse_bits[i]);
            #1 check("pulse_on", {device_reset, tx_reset, rx_reset}, 3'b100 >> i);
            @(posedge mclk);
            #1 check("pulse_off", {device_reset, tx_reset, rx_reset}, 0);
        end
        // grant hold, short then long
        for (int lh = 0; lh < 2; lh++) begin
            wr_reg(8'h08, lh ? 32'h0602_0000 : 32'h0600_0000);
            bus_grant <= 1'b1;
            @(posedge mclk);
            bus_grant <= 1'b0;
            n = 0;
            repeat (14) begin
                #1 if (grant_hold === 1'b1) n++;
                @(posedge mclk);
            end
            check("hold_len", n, lh ? 10 : `HOLD_SHORT_CYC);
        end
        // self-ID error raised then cleared; clear bit is write-only
        sid_error_event <= 1'b1;
        @(posedge mclk);
        sid_error_event <= 1'b0;
        #1 check("sid_set", sid_error_flag, 1);
        wr_reg(8'h08, 32'h0600_0100);
        @(posedge mclk);
        #1 check("sid_clr", sid_error_flag, 0);
        rd_reg(8'h08, rd_val);
        check("sid_bit", rd_val, 32'h0600_0000);
        // event and clear strobe in one cycle: the event wins
        wr_reg(8'h08, 32'h0600_0100);
        sid_error_event <= 1'b1;
        @(posedge mclk);
        sid_error_event <= 1'b0;
        #1 check("sid_race", sid_error_flag, 1);
        // transmit one word, highest bit first
        @(posedge mclk);
        n = 0;
        while (tx_ready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        check("tx_ready_wait", tx_ready, 1);
        tx_word <= 32'hA5C3_0F81;
        tx_valid <= 1'b1;
        @(posedge mclk);
        tx_valid <= 1'b0;
        n = 0;
        while (tx_bit_valid !== 1'b1 && n < 6) begin
            @(posedge mclk);
            #1 n++;
        end
        check("tx_arb", tx_arb_req, 1);
        for (int b = 31; b >= 0; b--) begin
            check("tx_bit", {tx_bit_valid, tx_bit}, {1'b1, 1'(32'hA5C3_0F81 >> b)});
            @(posedge mclk);
            #1;
        end
        // receive: disabled, normal, busy to all, congested
        foreach (rx_ctl[i]) begin
            wr_reg(8'h08, rx_ctl[i]);
            rx_congested <= (i == 3);
            for (int b = 31; b >= 0; b--) begin
                rx_bit <= 1'(32'h3C96_E10B >> b);
                rx_bit_valid <= 1'b1;
                @(posedge mclk);
            end
            rx_bit_valid <= 1'b0;
            rx_bit <= 1'b1;
            n = 0;
            repeat (3) begin
                #1 if (rx_word_valid === 1'b1) begin
                    n++;
                    check("rx_word", rx_word, 32'h3C96_E10B);
                    check("busy", busy_ack, i >= 2);
                end
                @(posedge mclk);
            end
            check("rx_count", n, i != 0);
        end
        // mid-run reset brings back the power-on image
        wr_reg(8'h08, 32'h1002_0010);
        nrst <= 1'b0;
        @(posedge mclk);
        #1 check("pwr_mid_rst", power_switch_output, 0);
        check("ram_mid_rst", ram_addr, {23'h0, 1'b0, 8'h5A});
        check("tx_ready_mid_rst", tx_ready, 1);
        @(posedge mclk);
        nrst <= 1'b1;
        rd_reg(8'h08, rd_val);
        check("ctrl_mid_rst", rd_val, 32'h0600_0000);
        finish_test();
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        finish_test();
    end
endmodule // test_link_layer_control_registers
